// [cpu_instruction_execute.sv]
// The AHB-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
module cpu_instruction_execute #(
  parameter int STACK_DEPTH = 8 // Stack levels, a power of two.
) (
  input wire logic CLK_I, // System clock.
  input wire logic SYS_RST_I, // Synchronous reset, active high.
  input wire logic HSEL_I, // Slave select.
  input wire logic [31:0] HADDR_I, // Byte address.
  input wire logic [1:0] HTRANS_I, // Transfer type.
  input wire logic HWRITE_I, // Write when high.
  input wire logic [2:0] HSIZE_I, // Transfer size, word only.
  input wire logic [31:0] HWDATA_I, // Write data.
  input wire logic HREADY_I, // Bus ready.
  output logic [31:0] HRDATA_O, // Read data.
  output logic HREADYOUT_O, // Slave ready, always high.
  output logic HRESP_O, // Always OKAY.
  output logic [15:0] ROM_ADDR_O, // Program ROM address.
  input wire logic [15:0] ROM_DATA_I, // Program ROM word, same cycle.
  output logic [9:0] MEM_ADDR_O, // Data memory address, bank and offset.
  input wire logic [7:0] MEM_RDATA_I, // Data memory read, same cycle.
  output logic [7:0] MEM_WDATA_O, // Data memory write data.
  output logic MEM_WE_O, // Data memory write enable.
  input wire logic WATCHDOG_TIMEOUT_STATUS_I, // Status bit from reset logic.
  input wire logic POWERDOWN_STATUS_I, // Status bit from reset logic.
  output logic GIE_O // Global interrupt enable.
);

  localparam int SPW = $clog2(STACK_DEPTH);

  function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b,
                                      input logic ci);
    add9 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
  endfunction : add9

  function automatic logic [8:0] sub9(input logic [7:0] a, input logic [7:0] b,
                                      input logic bi);
    sub9 = {1'b0, a} - {1'b0, b} - {8'h00, bi};
  endfunction : sub9

  cx_pkg::exec_state_t state_q, state_d;
  logic [15:0] ir_q, pc_q;
  logic [7:0] wreg_q, sh_wreg_q, ptr_hi_q, ptr_lo_q, r_q, waddr_lo_q, wdata_q;
  logic [1:0] waddr_bk_q, page_q, bank_q;
  logic c_q, z_q, sh_c_q, sh_z_q, gie_q, run_q, skip_pend_q;
  logic [15:0] stk_q [STACK_DEPTH];
  logic [SPW-1:0] sp_q;
  logic [7:0] res, flag_w;
  logic c_n;

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  wire [1:0] grp = ir_q[15:14];
  wire [5:0] op = ir_q[13:8];
  wire [2:0] bsub = ir_q[13:11];
  wire [2:0] bidx = ir_q[10:8];
  wire [7:0] opnd = ir_q[7:0];
  wire alu = grp == cx_pkg::GRP_ALU;
  wire bit_op = grp == cx_pkg::GRP_BIT;
  wire exec = run_q && state_q == cx_pkg::ST_EXEC;

  wire imm_f = alu && op inside {cx_pkg::OP_ADD_I, cx_pkg::OP_SUB_I, cx_pkg::OP_AND_I,
    cx_pkg::OP_OR_I, cx_pkg::OP_XOR_I, cx_pkg::OP_CMPSK_I};
  wire mem_dst = (bit_op && !bsub[cx_pkg::BSUB_TEST]) || (alu && op inside {
    cx_pkg::OP_ADDC_M, cx_pkg::OP_ADD_M, cx_pkg::OP_BZSUM_M, cx_pkg::OP_SUBB_M,
    cx_pkg::OP_SUB_M, cx_pkg::OP_AND_M, cx_pkg::OP_OR_M, cx_pkg::OP_XOR_M,
    cx_pkg::OP_NIB_M, cx_pkg::OP_ROR_M, cx_pkg::OP_ROL_M, cx_pkg::OP_INCSK_M,
    cx_pkg::OP_DECSK_M});
  wire wreg_dst = alu && op inside {cx_pkg::OP_ADDC_A, cx_pkg::OP_ADD_A, cx_pkg::OP_ADD_I,
    cx_pkg::OP_SUBB_A, cx_pkg::OP_SUB_A, cx_pkg::OP_SUB_I, cx_pkg::OP_AND_A,
    cx_pkg::OP_AND_I, cx_pkg::OP_OR_A, cx_pkg::OP_OR_I, cx_pkg::OP_XOR_A,
    cx_pkg::OP_XOR_I, cx_pkg::OP_NIB_A, cx_pkg::OP_ROR_A, cx_pkg::OP_ROL_A,
    cx_pkg::OP_INCSK_A, cx_pkg::OP_DECSK_A};
  wire use_c = alu && op inside {cx_pkg::OP_ADDC_A, cx_pkg::OP_ADDC_M,
    cx_pkg::OP_SUBB_A, cx_pkg::OP_SUBB_M};
  wire is_add = alu && op inside {cx_pkg::OP_ADDC_A, cx_pkg::OP_ADDC_M, cx_pkg::OP_ADD_A,
    cx_pkg::OP_ADD_M, cx_pkg::OP_BZSUM_M, cx_pkg::OP_ADD_I};
  wire is_cmp = alu && op inside {cx_pkg::OP_CMPSK_I, cx_pkg::OP_CMPSK_M};
  wire is_sub = is_cmp || (alu && op inside {cx_pkg::OP_SUBB_A, cx_pkg::OP_SUBB_M,
    cx_pkg::OP_SUB_A, cx_pkg::OP_SUB_M, cx_pkg::OP_SUB_I});
  wire is_logic = alu && op inside {cx_pkg::OP_AND_A, cx_pkg::OP_AND_M, cx_pkg::OP_AND_I,
    cx_pkg::OP_OR_A, cx_pkg::OP_OR_M, cx_pkg::OP_OR_I, cx_pkg::OP_XOR_A,
    cx_pkg::OP_XOR_M, cx_pkg::OP_XOR_I};
  wire is_ror = alu && op inside {cx_pkg::OP_ROR_A, cx_pkg::OP_ROR_M};
  wire is_rol = alu && op inside {cx_pkg::OP_ROL_A, cx_pkg::OP_ROL_M};
  wire is_incdec = alu && op inside {cx_pkg::OP_INCSK_A, cx_pkg::OP_INCSK_M,
    cx_pkg::OP_DECSK_A, cx_pkg::OP_DECSK_M};
  wire is_ret = alu && op inside {cx_pkg::OP_RET, cx_pkg::OP_IRET};
  wire is_look = alu && op == cx_pkg::OP_LOOKUP;
  wire is_save = alu && op == cx_pkg::OP_SAVE;
  wire is_rest = alu && op == cx_pkg::OP_RESTORE;

  // Bank-zero forms ignore the current bank select.
  wire bank0 = bit_op ? bsub[cx_pkg::BSUB_BANK0] : (alu && op == cx_pkg::OP_BZSUM_M);
  wire [9:0] maddr = {bank0 ? 2'b00 : bank_q, opnd};

  // --------------------------------------------------------------------------
  // Datapath
  // --------------------------------------------------------------------------
  wire [7:0] bval = imm_f ? opnd : MEM_RDATA_I;
  wire [8:0] sum_w = add9(wreg_q, bval, use_c && c_q);
  wire [8:0] dif_w = sub9(wreg_q, bval, use_c && !c_q);
  wire [8:0] inc_w = add9(MEM_RDATA_I, 8'h00, 1'b1);
  wire [8:0] dec_w = sub9(MEM_RDATA_I, 8'h00, 1'b1);
  always_comb begin
    res = MEM_RDATA_I;
    if (bit_op) begin
      res[bidx] = bsub[cx_pkg::BSUB_VAL];
    end else if (is_add) begin
      res = sum_w[7:0];
    end else if (is_sub) begin
      res = dif_w[7:0];
    end else if (alu) begin
      case (op)
        cx_pkg::OP_AND_A, cx_pkg::OP_AND_M, cx_pkg::OP_AND_I: res = wreg_q & bval;
        cx_pkg::OP_OR_A, cx_pkg::OP_OR_M, cx_pkg::OP_OR_I: res = wreg_q | bval;
        cx_pkg::OP_XOR_A, cx_pkg::OP_XOR_M, cx_pkg::OP_XOR_I: res = wreg_q ^ bval;
        cx_pkg::OP_NIB_A, cx_pkg::OP_NIB_M: res = {MEM_RDATA_I[3:0], MEM_RDATA_I[7:4]};
        cx_pkg::OP_ROR_A, cx_pkg::OP_ROR_M: res = {c_q, MEM_RDATA_I[7:1]};
        cx_pkg::OP_ROL_A, cx_pkg::OP_ROL_M: res = {MEM_RDATA_I[6:0], c_q};
        cx_pkg::OP_INCSK_A, cx_pkg::OP_INCSK_M: res = inc_w[7:0];
        cx_pkg::OP_DECSK_A, cx_pkg::OP_DECSK_M: res = dec_w[7:0];
        default: res = MEM_RDATA_I;
      endcase
    end
  end
  // Carry high means no borrow on the subtract side.
  wire c_wr = is_add || is_sub || is_ror || is_rol;
  assign c_n = is_add ? sum_w[8] : is_sub ? !dif_w[8] : is_ror ? MEM_RDATA_I[0] :
               MEM_RDATA_I[7];
  wire z_wr = is_add || is_sub || is_logic;
  wire skip_w = (is_cmp && dif_w[7:0] == 8'h00) ||
                (is_incdec && res == 8'h00) ||
                (bit_op && bsub[cx_pkg::BSUB_TEST] &&
                 MEM_RDATA_I[bidx] == bsub[cx_pkg::BSUB_VAL]);

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  // RAM results are written from flops one cycle later; system registers are
  // written in the executing cycle so no time is added.
  wire is_sys = opnd >= cx_pkg::SYS_BASE;
  wire ram_wr = exec && mem_dst && !is_sys;
  wire sys_wr = exec && mem_dst && is_sys;
  wire redirect = exec && (grp[1] || is_ret || is_look);
  wire advance = run_q && !(state_q == cx_pkg::ST_EXEC && (redirect || ram_wr));
  wire [SPW-1:0] sp_dn = sp_q - 1'b1;
  wire [15:0] pc_tgt = grp[1] ? {page_q, ir_q[13:0]} : stk_q[sp_dn];

  always_comb begin
    state_d = state_q;
    if (run_q) begin
      case (state_q)
        cx_pkg::ST_EXEC: state_d = redirect ? cx_pkg::ST_FILL : ram_wr ? cx_pkg::ST_WRITE :
                                   skip_w ? cx_pkg::ST_SKIP : cx_pkg::ST_EXEC;
        cx_pkg::ST_WRITE: state_d = skip_pend_q ? cx_pkg::ST_SKIP : cx_pkg::ST_EXEC;
        default: state_d = cx_pkg::ST_EXEC;
      endcase
    end
  end
  // A pending skip is held while the core is stopped, so it survives a pause.
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state_q <= cx_pkg::ST_FILL;
      skip_pend_q <= 1'b0;
    end else begin
      state_q <= state_d;
      skip_pend_q <= run_q ? ram_wr && skip_w : skip_pend_q;
    end
  end

  // A skipped word is loaded into ir_q and then overwritten unexecuted.
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      pc_q <= cx_pkg::PC_RST;
      ir_q <= cx_pkg::PC_RST;
    end else if (redirect && !is_look) begin
      pc_q <= pc_tgt;
    end else if (advance) begin
      pc_q <= pc_q + 16'h0001;
      ir_q <= ROM_DATA_I;
    end
  end
  always_ff @(posedge CLK_I) begin
    if (ram_wr) begin
      waddr_bk_q <= maddr[9:8];
      waddr_lo_q <= maddr[7:0];
      wdata_q <= res;
    end
  end

  // --------------------------------------------------------------------------
  // Stack and architectural registers
  // --------------------------------------------------------------------------
  // The stack wraps silently; deeper nesting overwrites the oldest return.
  always_ff @(posedge CLK_I) begin
    if (exec && grp == cx_pkg::GRP_CALL) begin
      stk_q[sp_q] <= pc_q;
    end
  end
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      sp_q <= '0;
    end else if (exec && grp == cx_pkg::GRP_CALL) begin
      sp_q <= sp_q + 1'b1;
    end else if (exec && is_ret) begin
      sp_q <= sp_dn;
    end
  end
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      wreg_q <= cx_pkg::BYTE_RST;
    end else if (exec && wreg_dst) begin
      wreg_q <= res;
    end else if (exec && is_look) begin
      wreg_q <= ROM_DATA_I[7:0];
    end else if (exec && is_rest) begin
      wreg_q <= sh_wreg_q;
    end
  end
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      c_q <= 1'b0;
      z_q <= 1'b0;
    end else if (exec && is_rest) begin
      c_q <= sh_c_q;
      z_q <= sh_z_q;
    end else if (exec) begin
      c_q <= c_wr ? c_n : c_q;
      z_q <= z_wr ? res == 8'h00 : z_q;
    end
  end

  // Only the working register and the carry and zero flags are shadowed; the status bits stay live.
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      sh_wreg_q <= cx_pkg::BYTE_RST;
      sh_c_q <= 1'b0;
      sh_z_q <= 1'b0;
    end else if (exec && is_save) begin
      sh_wreg_q <= wreg_q;
      sh_c_q <= c_q;
      sh_z_q <= z_q;
    end
  end

  // --------------------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------------------
  logic wr_pend_q, rd_pend_q;
  logic [7:0] bus_addr_q;
  logic [31:0] ctrl_w, ptr_w, stat_w, rd_mux;
  wire bus_take = HSEL_I && HREADY_I && HTRANS_I[1];
  wire wr_ctrl = wr_pend_q && bus_addr_q == cx_pkg::CTRL_OFS;
  wire wr_ptr = wr_pend_q && bus_addr_q == cx_pkg::PTR_OFS;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      bus_addr_q <= cx_pkg::BYTE_RST;
    end else begin
      wr_pend_q <= bus_take && HWRITE_I;
      rd_pend_q <= bus_take && !HWRITE_I;
      bus_addr_q <= bus_take ? HADDR_I[7:0] : bus_addr_q;
    end
  end

  // A hardware update in the same cycle as a bus write wins.
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      run_q <= cx_pkg::RUN_RST;
      page_q <= 2'b00;
      bank_q <= 2'b00;
      gie_q <= 1'b0;
    end else begin
      run_q <= wr_ctrl ? HWDATA_I[cx_pkg::CTRL_RUN] : run_q;
      page_q <= wr_ctrl ? HWDATA_I[cx_pkg::CTRL_PAGE +: 2] : page_q;
      bank_q <= wr_ctrl ? HWDATA_I[cx_pkg::CTRL_BANK +: 2] : bank_q;
      gie_q <= (exec && alu && op == cx_pkg::OP_IRET) ||
               (wr_ctrl ? HWDATA_I[cx_pkg::CTRL_GIE] : gie_q);
    end
  end
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ptr_hi_q <= cx_pkg::BYTE_RST;
      ptr_lo_q <= cx_pkg::BYTE_RST;
      r_q <= cx_pkg::BYTE_RST;
    end else begin
      ptr_hi_q <= wr_ptr ? HWDATA_I[cx_pkg::PTR_HI +: 8] : ptr_hi_q;
      ptr_lo_q <= wr_ptr ? HWDATA_I[cx_pkg::PTR_LO +: 8] : ptr_lo_q;
      r_q <= (exec && is_look) ? ROM_DATA_I[15:8] :
             wr_ptr ? HWDATA_I[cx_pkg::PTR_R +: 8] : r_q;
    end
  end
  always_comb begin
    flag_w = 8'h00;
    flag_w[cx_pkg::FLAG_C] = c_q;
    flag_w[cx_pkg::FLAG_Z] = z_q;
    flag_w[cx_pkg::FLAG_PD] = POWERDOWN_STATUS_I;
    flag_w[cx_pkg::FLAG_WDT] = WATCHDOG_TIMEOUT_STATUS_I;
    ctrl_w = 32'h0000_0000;
    ctrl_w[cx_pkg::CTRL_RUN] = run_q;
    ctrl_w[cx_pkg::CTRL_PAGE +: 2] = page_q;
    ctrl_w[cx_pkg::CTRL_BANK +: 2] = bank_q;
    ctrl_w[cx_pkg::CTRL_GIE] = gie_q;
    ptr_w = 32'h0000_0000;
    ptr_w[cx_pkg::PTR_LO +: 8] = ptr_lo_q;
    ptr_w[cx_pkg::PTR_HI +: 8] = ptr_hi_q;
    ptr_w[cx_pkg::PTR_R +: 8] = r_q;
    stat_w = 32'h0000_0000;
    stat_w[cx_pkg::SR_WREG +: 8] = wreg_q;
    stat_w[cx_pkg::SR_FLAG +: 8] = flag_w;
    stat_w[cx_pkg::SR_PC +: 16] = pc_q;
  end
  assign rd_mux = bus_addr_q == cx_pkg::CTRL_OFS ? ctrl_w :
                  bus_addr_q == cx_pkg::PTR_OFS ? ptr_w :
                  bus_addr_q == cx_pkg::STAT_OFS ? stat_w : 32'h0000_0000;
  assign HRDATA_O = rd_pend_q ? rd_mux : 32'h0000_0000;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;

  // --------------------------------------------------------------------------
  // Memory and ROM ports
  // --------------------------------------------------------------------------
  wire in_write = run_q && state_q == cx_pkg::ST_WRITE;
  assign ROM_ADDR_O = (exec && is_look) ? {ptr_hi_q, ptr_lo_q} : pc_q;
  assign MEM_ADDR_O = in_write ? {waddr_bk_q, waddr_lo_q} : maddr;
  assign MEM_WDATA_O = in_write ? wdata_q : res;
  assign MEM_WE_O = sys_wr || in_write;
  assign GIE_O = gie_q;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  branch_target_a: assert property (exec && grp == cx_pkg::GRP_BR |=>
    pc_q == {$past(page_q), $past(ir_q[13:0])} && state_q == cx_pkg::ST_FILL)
    else $error("far branch target wrong");
  call_push_a: assert property (exec && grp == cx_pkg::GRP_CALL |=>
    stk_q[$past(sp_q)] == $past(pc_q) && sp_q == SPW'($past(sp_q) + 1'b1))
    else $error("call did not push the PC");
  refill_two_a: assert property (redirect && run_q ##1 run_q |->
    state_q == cx_pkg::ST_FILL ##1 state_q == cx_pkg::ST_EXEC)
    else $error("redirect did not take two cycles");
  iret_enable_a: assert property (exec && alu && op == cx_pkg::OP_IRET |=> gie_q)
    else $error("interrupt return left interrupts off");
  ram_write_a: assert property (ram_wr && !skip_w |=>
    MEM_WE_O && MEM_ADDR_O == $past(maddr) && MEM_WDATA_O == $past(res)
    ##1 !(in_write))
    else $error("RAM write not one extra cycle");
  sys_write_a: assert property (sys_wr |-> MEM_WE_O && MEM_ADDR_O == maddr
    ##1 state_q != cx_pkg::ST_WRITE)
    else $error("system register write delayed");
  skip_annul_a: assert property (run_q && state_q == cx_pkg::ST_SKIP |-> !MEM_WE_O
    ##1 $stable(wreg_q) && $stable(c_q) && $stable(z_q) && $stable(sp_q))
    else $error("annulled word changed state");
  add_carry_a: assert property (exec && alu && op == cx_pkg::OP_ADD_A |=>
    {c_q, wreg_q} == {1'b0, $past(wreg_q)} + {1'b0, $past(MEM_RDATA_I)})
    else $error("add result or carry wrong");
  cmp_skip_a: assert property (exec && is_cmp && wreg_q == bval |=>
    state_q == cx_pkg::ST_SKIP && z_q && c_q && $stable(wreg_q))
    else $error("equal compare did not skip");
  lookup_load_a: assert property (exec && is_look |=>
    wreg_q == $past(ROM_DATA_I[7:0]) && r_q == $past(ROM_DATA_I[15:8]))
    else $error("table lookup load wrong");
  save_copy_a: assert property (exec && is_save |=> sh_wreg_q == $past(wreg_q))
    else $error("context save missed");
  skip_taken_c: cover property (exec && skip_w ##1 state_q == cx_pkg::ST_SKIP);
  ram_skip_c: cover property (ram_wr && skip_w ##2 state_q == cx_pkg::ST_SKIP);
  call_ret_c: cover property (exec && grp == cx_pkg::GRP_CALL ##[1:20] exec && is_ret);
  lookup_c: cover property (exec && is_look);

endmodule : cpu_instruction_execute

// [cx_pkg.sv]
package cx_pkg;

  // --------------------------------------------------------------------------
  // Instruction word layout
  // --------------------------------------------------------------------------
  localparam logic [1:0] GRP_ALU = 2'h0;
  localparam logic [1:0] GRP_BIT = 2'h1;
  localparam logic [1:0] GRP_BR = 2'h2;
  localparam logic [1:0] GRP_CALL = 2'h3;

  localparam logic [5:0] OP_NOP = 6'h00, OP_ADDC_A = 6'h01, OP_ADDC_M = 6'h02;
  localparam logic [5:0] OP_ADD_A = 6'h03, OP_ADD_M = 6'h04, OP_BZSUM_M = 6'h05;
  localparam logic [5:0] OP_ADD_I = 6'h06, OP_SUBB_A = 6'h07, OP_SUBB_M = 6'h08;
  localparam logic [5:0] OP_SUB_A = 6'h09, OP_SUB_M = 6'h0A, OP_SUB_I = 6'h0B;
  localparam logic [5:0] OP_AND_A = 6'h0C, OP_AND_M = 6'h0D, OP_AND_I = 6'h0E;
  localparam logic [5:0] OP_OR_A = 6'h0F, OP_OR_M = 6'h10, OP_OR_I = 6'h11;
  localparam logic [5:0] OP_XOR_A = 6'h12, OP_XOR_M = 6'h13, OP_XOR_I = 6'h14;
  localparam logic [5:0] OP_NIB_A = 6'h15, OP_NIB_M = 6'h16, OP_ROR_A = 6'h17;
  localparam logic [5:0] OP_ROR_M = 6'h18, OP_ROL_A = 6'h19, OP_ROL_M = 6'h1A;
  localparam logic [5:0] OP_CMPSK_I = 6'h1B, OP_CMPSK_M = 6'h1C, OP_INCSK_A = 6'h1D;
  localparam logic [5:0] OP_INCSK_M = 6'h1E, OP_DECSK_A = 6'h1F, OP_DECSK_M = 6'h20;
  localparam logic [5:0] OP_RET = 6'h21, OP_IRET = 6'h22, OP_SAVE = 6'h23;
  localparam logic [5:0] OP_RESTORE = 6'h24, OP_LOOKUP = 6'h25;

  // Bit group sub-op field: value, bank-zero and test bits.
  localparam int BSUB_VAL = 0;
  localparam int BSUB_BANK0 = 1;
  localparam int BSUB_TEST = 2;

  // Operand addresses at or above this are system registers.
  localparam logic [7:0] SYS_BASE = 8'h80;

  // --------------------------------------------------------------------------
  // Flag byte and bus register map
  // --------------------------------------------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 2;
  localparam int FLAG_PD = 6;
  localparam int FLAG_WDT = 7;

  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PTR_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;

  localparam int CTRL_RUN = 0;
  localparam int CTRL_PAGE = 1;
  localparam int CTRL_BANK = 4;
  localparam int CTRL_GIE = 8;
  localparam int PTR_LO = 0;
  localparam int PTR_HI = 8;
  localparam int PTR_R = 16;
  localparam int SR_WREG = 0;
  localparam int SR_FLAG = 8;
  localparam int SR_PC = 16;

  localparam logic RUN_RST = 1'b0;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef enum logic [1:0] {ST_FILL, ST_EXEC, ST_WRITE, ST_SKIP} exec_state_t;

endpackage : cx_pkg

// [mem_model.sv]
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// Program ROM and data memory, both read without a clock edge
// ----------------------------------------------------------------------------
module mem_model (
  input wire logic clk_i, // System clock.
  input wire logic [15:0] rom_addr_i, // ROM address.
  output logic [15:0] rom_data_o, // ROM word.
  input wire logic [9:0] mem_addr_i, // Data address.
  output logic [7:0] mem_rdata_o, // Data read.
  input wire logic [7:0] mem_wdata_i, // Data write.
  input wire logic mem_we_i // Write strobe.
);
  logic [15:0] rom [0:255];
  logic [7:0] ram [0:1023];
  // Only 256 words are modelled; the upper address bits alias.
  assign rom_data_o = rom[rom_addr_i[7:0]];
  assign mem_rdata_o = ram[mem_addr_i];
  always @(posedge clk_i) begin
    if (mem_we_i) begin
      ram[mem_addr_i] <= mem_wdata_i;
    end
  end
endmodule : mem_model

// [testbench.sv]
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module testbench;
  logic clk = 0, rst = 1, hsel = 0, hwrite = 0, rdy_q;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd_q, q;
  logic hreadyout, hresp, we, gie;
  logic [15:0] raddr, rdata;
  logic [9:0] maddr;
  logic [7:0] mrd, mwd;
  logic wdt_st = 0, pd_st = 0;
  int bad_count = 0, comparisons = 0;
  always #4 clk = ~clk;
  always @(posedge clk) rd_q <= hrdata;
  always @(posedge clk) rdy_q <= hreadyout;
  cpu_instruction_execute i_dut (.CLK_I(clk), .SYS_RST_I(rst), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
    .HWDATA_I(hwdata), .HREADY_I(hreadyout), .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout),
    .HRESP_O(hresp), .ROM_ADDR_O(raddr), .ROM_DATA_I(rdata), .MEM_ADDR_O(maddr),
    .MEM_RDATA_I(mrd), .MEM_WDATA_O(mwd), .MEM_WE_O(we), .WATCHDOG_TIMEOUT_STATUS_I(wdt_st),
    .POWERDOWN_STATUS_I(pd_st), .GIE_O(gie));
  mem_model i_mem (.clk_i(clk), .rom_addr_i(raddr), .rom_data_o(rdata), .mem_addr_i(maddr),
    .mem_rdata_o(mrd), .mem_wdata_i(mwd), .mem_we_i(we));
  // --------------------------------------------------------------------------
  // Bus and bench helpers
  // --------------------------------------------------------------------------
  task automatic finish_test;
    if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin @(posedge clk); #1; n++; end while (rdy_q !== 1'b1 && n < 20);
    if (n >= 20) begin bad_count++; $display("[FAIL] %0t bus hang", $time); finish_test(); end
  endtask : wait_rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h000000, a}; hwrite <= w;
    wait_rdy();
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    wait_rdy();
    q = rd_q;
  endtask : bus
  // Polls the status word until the core sits in its closing loop at pc a or b.
  task automatic run_until(input logic [15:0] a, input logic [15:0] b);
    int n;
    n = 0;
    do begin
      bus(1'b0, cx_pkg::STAT_OFS, 32'h0);
      n++;
    end while (q[31:16] !== a && q[31:16] !== b && n < 40);
    if (q[31:16] !== a && q[31:16] !== b) begin
      bad_count++;
      $display("[FAIL] %0t program hang", $time);
      finish_test();
    end
  endtask : run_until
  function automatic logic [15:0] alu(input logic [5:0] op, input logic [7:0] v);
    return {2'h0, op, v};
  endfunction : alu
  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic bus_map_test;
    bus(1'b0, cx_pkg::STAT_OFS, 32'h0); `CHK(q, 32'h00000000)
    bus(1'b0, 8'h0C, 32'h0); `CHK(q, 32'h00000000)
    bus(1'b1, cx_pkg::PTR_OFS, 32'h00123456);
    bus(1'b0, cx_pkg::PTR_OFS, 32'h0); `CHK(q[23:0], 24'h123456)
    `CHK(hresp, 1'b0)
    `CHK(hreadyout, 1'b1)
  endtask : bus_map_test
  task automatic program_test;
    i_mem.rom[0] = alu(cx_pkg::OP_ADD_I, 8'hF0);
    i_mem.rom[1] = alu(cx_pkg::OP_ADD_M, 8'h10);
    i_mem.rom[2] = alu(cx_pkg::OP_ADDC_M, 8'h11);
    i_mem.rom[3] = alu(cx_pkg::OP_NIB_A, 8'h10);
    i_mem.rom[4] = alu(cx_pkg::OP_INCSK_M, 8'h12);
    i_mem.rom[5] = alu(cx_pkg::OP_ADD_I, 8'h01);
    i_mem.rom[6] = 16'h4F13;
    i_mem.rom[7] = alu(cx_pkg::OP_CMPSK_I, 8'hC2);
    i_mem.rom[8] = alu(cx_pkg::OP_ADD_I, 8'h05);
    i_mem.rom[9] = 16'h8020;
    i_mem.rom[10] = alu(cx_pkg::OP_ADD_I, 8'h07);
    i_mem.rom[32] = alu(cx_pkg::OP_NOP, 8'h00);
    i_mem.rom[33] = 16'h8021;
    i_mem.ram[16] = 8'h3C; i_mem.ram[17] = 8'h01; i_mem.ram[18] = 8'hFF; i_mem.ram[19] = 8'h00;
    bus(1'b1, cx_pkg::CTRL_OFS, 32'h00000001);
    run_until(16'h0021, 16'h0022);
    bus(1'b1, cx_pkg::CTRL_OFS, 32'h00000000);
    bus(1'b0, cx_pkg::STAT_OFS, 32'h0);
    `CHK(q[31:16] >= 16'h0020, 1'b1)
    `CHK(q[7:0], 8'hC2)
    `CHK(q[8], 1'b1)
    `CHK(q[10], 1'b1)
    `CHK(i_mem.ram[16], 8'h2C)
    `CHK(i_mem.ram[17], 8'hF2)
    `CHK(i_mem.ram[18], 8'h00)
    `CHK(i_mem.ram[19], 8'h80)
    `CHK(gie, 1'b0)
  endtask : program_test
  task automatic core_ops_test;
    i_mem.rom[0] = alu(cx_pkg::OP_ADD_I, 8'h35);
    i_mem.rom[1] = alu(cx_pkg::OP_LOOKUP, 8'h00);
    i_mem.rom[2] = alu(cx_pkg::OP_SAVE, 8'h00);
    i_mem.rom[3] = alu(cx_pkg::OP_SUB_I, 8'h5B);
    i_mem.rom[4] = alu(cx_pkg::OP_SUBB_A, 8'h20);
    i_mem.rom[5] = alu(cx_pkg::OP_ROR_A, 8'h20);
    i_mem.rom[6] = alu(cx_pkg::OP_XOR_I, 8'hFF);
    i_mem.rom[7] = alu(cx_pkg::OP_BZSUM_M, 8'h21);
    i_mem.rom[8] = 16'hC030;
    i_mem.rom[9] = alu(cx_pkg::OP_AND_I, 8'h0F);
    i_mem.rom[10] = alu(cx_pkg::OP_DECSK_A, 8'h23);
    i_mem.rom[11] = alu(cx_pkg::OP_ADD_I, 8'h40);
    i_mem.rom[12] = 16'h7B21;
    i_mem.rom[13] = alu(cx_pkg::OP_OR_I, 8'h80);
    i_mem.rom[14] = alu(cx_pkg::OP_OR_I, 8'h06);
    i_mem.rom[15] = alu(cx_pkg::OP_OR_M, 8'h90);
    i_mem.rom[16] = 16'h8010;
    i_mem.rom[48] = alu(cx_pkg::OP_ROL_M, 8'h22);
    i_mem.rom[49] = alu(cx_pkg::OP_RESTORE, 8'h00);
    i_mem.rom[50] = alu(cx_pkg::OP_IRET, 8'h00);
    i_mem.rom[64] = 16'hA55A;
    i_mem.ram[33] = 8'h90;
    i_mem.ram[288] = 8'h0F;
    i_mem.ram[290] = 8'hC1;
    i_mem.ram[291] = 8'h01;
    i_mem.ram[400] = 8'h30;
    wdt_st <= 1'b1;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk); #1;
    bus(1'b0, cx_pkg::STAT_OFS, 32'h0); `CHK(q, 32'h00008000)
    bus(1'b0, cx_pkg::PTR_OFS, 32'h0); `CHK(q, 32'h00000000)
    bus(1'b1, cx_pkg::PTR_OFS, 32'h00000040);
    bus(1'b1, cx_pkg::CTRL_OFS, 32'h00000011);
    run_until(16'h0010, 16'h0011);
    `CHK(gie, 1'b1)
    bus(1'b1, cx_pkg::CTRL_OFS, 32'h00000000);
    bus(1'b0, cx_pkg::STAT_OFS, 32'h0);
    `CHK(q[7:0], 8'h06)
    `CHK(q[8], 1'b0)
    `CHK(q[15:14], 2'b10)
    `CHK(i_mem.ram[33], 8'h08)
    `CHK(i_mem.ram[290], 8'h83)
    `CHK(i_mem.ram[400], 8'h36)
    bus(1'b0, cx_pkg::PTR_OFS, 32'h0); `CHK(q[23:16], 8'hA5)
  endtask : core_ops_test
  initial begin
    for (int i = 0; i < 256; i++) i_mem.rom[i] = 16'h0000;
    for (int i = 0; i < 1024; i++) i_mem.ram[i] = 8'h00;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk); #1;
    bus_map_test();
    program_test();
    core_ops_test();
    finish_test();
  end
endmodule : testbench
